// ### inc/swt_defs.vh
// Constants for the scan watchdog and timer block: register offsets,
// field positions, reset values and timing figures.
// Assumes a 250 MHz core clock and byte addresses on a 32-bit bus.
`ifndef SWT_DEFS_VH
`define SWT_DEFS_VH

// Clock rate in kHz, so a time in ms times this gives cycles.
`define SWT_CLK_KHZ 250000
// Time base of every count in ms.
`define SWT_TICK_MS 1
// Longest supply dropout that execution rides through, in ms.
`define SWT_DROP_MS 10

// Register byte offsets.
`define SWT_REG_CTRL 7'h00
`define SWT_REG_CMD 7'h04
`define SWT_REG_WD_LIMIT 7'h08
`define SWT_REG_WD_ELAPSED 7'h0c
`define SWT_REG_TASK_IVL 7'h10
`define SWT_REG_STATUS 7'h14
`define SWT_REG_IRQ_MASK 7'h18
`define SWT_REG_SCAN_LATEST 7'h1c
`define SWT_REG_SCAN_MAX 7'h20
`define SWT_REG_SCAN_MIN 7'h24
`define SWT_REG_TMR_EVAL 7'h28
`define SWT_REG_TMR_Q 7'h2c
`define SWT_REG_PRESET0 7'h30
`define SWT_REG_ELAPSED0 7'h3c
`define SWT_REG_STATE 7'h48

// Field positions.
`define SWT_CTRL_RUN 0
`define SWT_CMD_WD_RESTART 0
`define SWT_EVT_WD_ERR 0
`define SWT_EVT_PWR_HALT 1
`define SWT_EVT_TASK 2
`define SWT_EVT_SCAN 3
`define SWT_EVAL_IN_LSB 4

// Reset values.
`define SWT_CTRL_RST 1'b0
`define SWT_WD_LIMIT_RST 16'h00c8
`define SWT_TASK_IVL_RST 32'h0000_0000
`define SWT_SCAN_MIN_RST 32'hffff_ffff

// Timer kinds.
`define SWT_MODE_ON 2'h0
`define SWT_MODE_OFF 2'h1
`define SWT_MODE_PULSE 2'h2

`endif

// ### design/swt_timer.v
// One elapsed-time timer of selectable kind: on-delay, off-delay or pulse.
// Assumes a free-running ms count from the parent and an evaluation strobe
// that stands for the program executing this timer once in a scan.
`timescale 1ns/100ps
`default_nettype none
`include "swt_defs.vh"

module swt_timer #(
	parameter [1:0] MODE = `SWT_MODE_ON
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Evaluation by the program.
	input wire eval,
	input wire in_lvl,
	input wire [31:0] preset,
	input wire [31:0] now,
	// Timer state.
	output reg [31:0] et_q,
	output reg q_q
);

	reg run_q;
	reg prev_q;
	reg [31:0] start_q;
	wire [31:0] sat;

	// Elapsed since start, held at the preset so it never runs past it.
	function [31:0] swt_sat;
		input [31:0] n;
		input [31:0] s;
		input [31:0] p;
		reg [31:0] e;
		begin
			e = n - s;
			swt_sat = (e >= p) ? p : e;
		end
	endfunction

	assign sat = swt_sat(now, start_q, preset);

	// State changes only on evaluation, never between evaluations.
	// update at evaluation
	always @(posedge clk) begin
		if (rst) begin
			et_q <= 32'h0000_0000;
			q_q <= 1'b0;
			run_q <= 1'b0;
			prev_q <= 1'b0;
			start_q <= 32'h0000_0000;
		end else if (eval) begin
			prev_q <= in_lvl;
			case (MODE)
			`SWT_MODE_ON: begin
				if (!in_lvl) begin
					et_q <= 32'h0000_0000;
					q_q <= 1'b0;
					run_q <= 1'b0;
				end else if (!run_q) begin
					run_q <= 1'b1;
					start_q <= now;
					et_q <= 32'h0000_0000;
					q_q <= (preset == 32'h0000_0000);
				end else begin
					et_q <= sat;
					q_q <= (sat == preset);
				end
			end
			`SWT_MODE_OFF: begin
				if (in_lvl) begin
					q_q <= 1'b1;
					run_q <= 1'b0;
					et_q <= 32'h0000_0000;
				end else if (q_q) begin
					if (!run_q) begin
						run_q <= 1'b1;
						start_q <= now;
						et_q <= 32'h0000_0000;
						q_q <= (preset != 32'h0000_0000);
					end else begin
						et_q <= sat;
						q_q <= (sat != preset);
					end
				end
			end
			`SWT_MODE_PULSE: begin
				if (run_q) begin
					et_q <= sat;
					if (sat == preset) begin
						q_q <= 1'b0;
						run_q <= 1'b0;
					end
				end else if (in_lvl && !prev_q) begin
					run_q <= (preset != 32'h0000_0000);
					start_q <= now;
					et_q <= 32'h0000_0000;
					q_q <= (preset != 32'h0000_0000);
				end else if (!in_lvl) begin
					et_q <= 32'h0000_0000;
				end
			end
			default: begin
				q_q <= 1'b0;
			end
			endcase
		end
	end

endmodule // swt_timer
`default_nettype wire

// ### design/swt_top.v
// Scan timekeeping of a scan-driven controller CPU: watchdog, scan-time
// statistics, time-driven task interval, dropout handling, three timers.
// Assumes an Avalon-MM master on CLOCK, a same-clock scan start pulse from
// the sequencer, and asynchronous supply-good and manual reset pins.
//
// Function
// - Task fires once per programmed interval, 1 ms steps.
// - Dropout under 10 ms keeps running, outputs unchanged.
// - Longer dropout halts, outputs off, resumes after.
// - Scan time runs step-0 entry to next.
// - Keep largest, smallest, latest scan in ms.
// - Watchdog overrun stops, forces outputs off, flags.
// - Restart request sets watchdog elapsed to zero.
// - Error cleared by manual reset or stop.
// - Watchdog limit 1 to 65535 ms; code loads 0 when the low half is 0 but upper bits are set.
// - Timers count up in 1 ms, 32-bit presets.
// - Timer elapsed updates only when evaluated.
// - On-delay output on when elapsed equals preset.
// - Off-delay on with input, off after preset.
// - Pulse output ends at preset despite input.
// - Timer error bounded by scan plus evaluation delay.
`timescale 1ns/100ps
`default_nettype none
`include "swt_defs.vh"

module swt_top #(
	// Cycles per 1 ms tick; shorten in simulation.
	parameter [31:0] TICK_CYCLES = `SWT_TICK_MS * `SWT_CLK_KHZ,
	// Cycles of dropout tolerated before halting.
	parameter [31:0] DROP_CYCLES = `SWT_DROP_MS * `SWT_CLK_KHZ
) (
	// Clock and reset.
	input wire CLOCK,
	input wire RST,
	// Avalon-MM slave.
	input wire [6:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	// Sequencer and pins.
	input wire SCAN_START,
	input wire PWR_OK,
	input wire MANUAL_RESET,
	// Results.
	output wire IRQ,
	output wire OUTPUT_EN,
	output wire CPU_HALT,
	output reg TASK_FIRE,
	output wire [2:0] TIMER_Q
);

	reg ack_q;
	reg run_mode_q;
	reg [15:0] wd_limit_q;
	reg [15:0] wd_elapsed_q;
	reg wd_err_q;
	reg [31:0] task_ivl_q;
	reg [31:0] task_cnt_q;
	reg [3:0] status_q;
	reg [3:0] status_d;
	reg [3:0] mask_q;
	reg [31:0] scan_cnt_q;
	reg [31:0] scan_latest_q;
	reg [31:0] scan_max_q;
	reg [31:0] scan_min_q;
	reg scan_seen_q;
	reg [31:0] tick_cnt_q;
	reg tick_q;
	reg [31:0] ms_now_q;
	reg [31:0] drop_cnt_q;
	reg pwr_halt_q;
	reg pwr_m_q;
	reg pwr_s_q;
	reg man_m_q;
	reg man_s_q;
	reg [31:0] preset_q [0:2];
	reg [2:0] eval_q;
	reg [2:0] eval_in_q;
	reg [31:0] rd_d;
	wire [31:0] et [0:2];
	wire wr_go;
	wire [31:0] be_m;
	wire running;
	wire wd_trip;
	wire wd_restart;
	wire stop_wr;
	wire task_hit;
	wire drop_long;
	wire [3:0] events;
	wire timer_q0;
	wire timer_q1;
	wire timer_q2;

	// Merge write data into a register under the byte mask.
	function [31:0] swt_merge;
		input [31:0] old;
		input [31:0] wd;
		input [31:0] m;
		begin
			swt_merge = (old & ~m) | (wd & m);
		end
	endfunction

	// Limit and mask words as a write would leave them, before narrowing.
	wire [31:0] lim_new = swt_merge({16'h0000, wd_limit_q}, AVS_WRITEDATA, be_m);
	wire [31:0] mask_new = swt_merge({28'h0000000, mask_q}, AVS_WRITEDATA, be_m);

	// Every request waits exactly one cycle, which gives the read mux a
	// registered path without slowing writes further.
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign wr_go = AVS_WRITE & ack_q;
	assign be_m = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

	// Execution stands still on error, long dropout or stop mode.
	// stop and outputs off
	assign running = run_mode_q & ~wd_err_q & ~pwr_halt_q;
	assign OUTPUT_EN = running;
	assign CPU_HALT = ~running;
	assign TIMER_Q = {3{running}} & {timer_q2, timer_q1, timer_q0};

	assign wd_restart = wr_go && (AVS_ADDRESS == `SWT_REG_CMD) && AVS_BYTEENABLE[0]
		&& AVS_WRITEDATA[`SWT_CMD_WD_RESTART];
	assign stop_wr = wr_go && (AVS_ADDRESS == `SWT_REG_CTRL) && AVS_BYTEENABLE[0]
		&& !AVS_WRITEDATA[`SWT_CTRL_RUN];
	assign wd_trip = running && (wd_elapsed_q > wd_limit_q);
	assign task_hit = running && tick_q && (task_ivl_q != 32'h0000_0000)
		&& (task_cnt_q + 32'h0000_0001 >= task_ivl_q);
	assign drop_long = (drop_cnt_q > DROP_CYCLES);

	// Pins pass two flip-flops before any logic reads them.
	always @(posedge CLOCK) begin
		if (RST) begin
			pwr_m_q <= 1'b1;
			pwr_s_q <= 1'b1;
			man_m_q <= 1'b0;
			man_s_q <= 1'b0;
		end else begin
			pwr_m_q <= PWR_OK;
			pwr_s_q <= pwr_m_q;
			man_m_q <= MANUAL_RESET;
			man_s_q <= man_m_q;
		end
	end

	// The 1 ms time base and the free-running ms count used by timers.
	// 1 ms resolution
	always @(posedge CLOCK) begin
		if (RST) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
			ms_now_q <= 32'h0000_0000;
		end else begin
			tick_q <= (tick_cnt_q == TICK_CYCLES - 32'h0000_0001);
			if (tick_cnt_q == TICK_CYCLES - 32'h0000_0001) begin
				tick_cnt_q <= 32'h0000_0000;
				ms_now_q <= ms_now_q + 32'h0000_0001;
			end else begin
				tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			end
		end
	end

	// Dropout timing: a short dip leaves everything alone, a long one halts
	// until supply returns, then execution picks up again by itself.
	// short dip ignored
	always @(posedge CLOCK) begin
		if (RST) begin
			drop_cnt_q <= 32'h0000_0000;
			pwr_halt_q <= 1'b0;
		end else if (pwr_s_q) begin
			drop_cnt_q <= 32'h0000_0000;
			pwr_halt_q <= 1'b0;
		end else begin
			if (!drop_long) begin
				drop_cnt_q <= drop_cnt_q + 32'h0000_0001;
			end
			if (drop_long) begin
				pwr_halt_q <= 1'b1;
			end
		end
	end

	// Watchdog elapsed count and its latched error.
	always @(posedge CLOCK) begin
		if (RST) begin
			wd_elapsed_q <= 16'h0000;
			wd_err_q <= 1'b0;
		end else begin
			if (SCAN_START || wd_restart || !running) begin
				wd_elapsed_q <= 16'h0000;
			end else if (tick_q && wd_elapsed_q != 16'hffff) begin
				wd_elapsed_q <= wd_elapsed_q + 16'h0001;
			end
			// only these clear it; a trip in the same cycle wins.
			if (wd_trip) begin
				wd_err_q <= 1'b1;
			end else if (man_s_q || stop_wr) begin
				wd_err_q <= 1'b0;
			end
		end
	end

	// Scan time from one step-0 entry to the next, with extremes.
	// step 0 to step 0
	always @(posedge CLOCK) begin
		if (RST) begin
			scan_cnt_q <= 32'h0000_0000;
			scan_latest_q <= 32'h0000_0000;
			scan_max_q <= 32'h0000_0000;
			scan_min_q <= `SWT_SCAN_MIN_RST;
			scan_seen_q <= 1'b0;
		end else if (SCAN_START) begin
			scan_cnt_q <= 32'h0000_0000;
			scan_seen_q <= 1'b1;
			if (scan_seen_q) begin
				scan_latest_q <= scan_cnt_q;
				if (scan_cnt_q > scan_max_q) begin
					scan_max_q <= scan_cnt_q;
				end
				if (scan_cnt_q < scan_min_q) begin
					scan_min_q <= scan_cnt_q;
				end
			end
		end else if (tick_q && scan_cnt_q != 32'hffff_ffff) begin
			scan_cnt_q <= scan_cnt_q + 32'h0000_0001;
		end
	end

	// Time-driven task: one pulse per elapsed interval, not per scan.
	// fire once per interval
	always @(posedge CLOCK) begin
		if (RST) begin
			task_cnt_q <= 32'h0000_0000;
			TASK_FIRE <= 1'b0;
		end else begin
			TASK_FIRE <= task_hit;
			if (!running || task_ivl_q == 32'h0000_0000 || task_hit) begin
				task_cnt_q <= 32'h0000_0000;
			end else if (tick_q) begin
				task_cnt_q <= task_cnt_q + 32'h0000_0001;
			end
		end
	end

	// Sticky events; a new event beats a clear in the same cycle.
	assign events = {SCAN_START, task_hit, drop_long & ~pwr_halt_q, wd_trip & ~wd_err_q};
	always @* begin
		status_d = status_q;
		if (wr_go && AVS_ADDRESS == `SWT_REG_STATUS) begin
			status_d = status_q & ~(AVS_WRITEDATA[3:0] & be_m[3:0]);
		end
		status_d = status_d | events;
	end
	assign IRQ = |(status_q & mask_q);

	// Software-written registers.
	always @(posedge CLOCK) begin
		if (RST) begin
			ack_q <= 1'b0;
			run_mode_q <= `SWT_CTRL_RST;
			wd_limit_q <= `SWT_WD_LIMIT_RST;
			task_ivl_q <= `SWT_TASK_IVL_RST;
			status_q <= 4'h0;
			mask_q <= 4'h0;
			preset_q[0] <= 32'h0000_0000;
			preset_q[1] <= 32'h0000_0000;
			preset_q[2] <= 32'h0000_0000;
			eval_q <= 3'h0;
			eval_in_q <= 3'h0;
		end else begin
			ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
			status_q <= status_d;
			eval_q <= 3'h0;
			if (wr_go) begin
				case (AVS_ADDRESS)
				`SWT_REG_CTRL: begin
					if (AVS_BYTEENABLE[0]) begin
						run_mode_q <= AVS_WRITEDATA[`SWT_CTRL_RUN];
					end
				end
				`SWT_REG_WD_LIMIT: begin
					// a zero word is held at 1 ms; nonzero upper bits let a zero low half through as 0
					wd_limit_q <= (lim_new == 32'h0000_0000) ? 16'h0001 : lim_new[15:0];
				end
				`SWT_REG_TASK_IVL: task_ivl_q <= swt_merge(task_ivl_q, AVS_WRITEDATA, be_m);
				`SWT_REG_IRQ_MASK: mask_q <= mask_new[3:0];
				`SWT_REG_PRESET0: preset_q[0] <= swt_merge(preset_q[0], AVS_WRITEDATA, be_m);
				`SWT_REG_PRESET0 + 7'h04: preset_q[1] <= swt_merge(preset_q[1], AVS_WRITEDATA, be_m);
				`SWT_REG_PRESET0 + 7'h08: preset_q[2] <= swt_merge(preset_q[2], AVS_WRITEDATA, be_m);
				`SWT_REG_TMR_EVAL: begin
					// evaluated when the program reaches it
					if (AVS_BYTEENABLE[0]) begin
						eval_q <= AVS_WRITEDATA[2:0];
						eval_in_q <= AVS_WRITEDATA[`SWT_EVAL_IN_LSB +: 3];
					end
				end
				default: ack_q <= 1'b0;
				endcase
			end
		end
	end

	// Read mux; unmapped addresses read as zero.
	always @* begin
		case (AVS_ADDRESS)
		`SWT_REG_CTRL: rd_d = {31'h0, run_mode_q};
		`SWT_REG_WD_LIMIT: rd_d = {16'h0, wd_limit_q};
		`SWT_REG_WD_ELAPSED: rd_d = {16'h0, wd_elapsed_q};
		`SWT_REG_TASK_IVL: rd_d = task_ivl_q;
		`SWT_REG_STATUS: rd_d = {28'h0, status_q};
		`SWT_REG_IRQ_MASK: rd_d = {28'h0, mask_q};
		`SWT_REG_SCAN_LATEST: rd_d = scan_latest_q;
		`SWT_REG_SCAN_MAX: rd_d = scan_max_q;
		`SWT_REG_SCAN_MIN: rd_d = scan_min_q;
		`SWT_REG_TMR_Q: rd_d = {29'h0, timer_q2, timer_q1, timer_q0};
		`SWT_REG_PRESET0: rd_d = preset_q[0];
		`SWT_REG_PRESET0 + 7'h04: rd_d = preset_q[1];
		`SWT_REG_PRESET0 + 7'h08: rd_d = preset_q[2];
		`SWT_REG_ELAPSED0: rd_d = et[0];
		`SWT_REG_ELAPSED0 + 7'h04: rd_d = et[1];
		`SWT_REG_ELAPSED0 + 7'h08: rd_d = et[2];
		`SWT_REG_STATE: rd_d = {28'h0, running, pwr_halt_q, wd_err_q, run_mode_q};
		default: rd_d = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the wait cycle and stands at the accept edge.
	always @(posedge CLOCK) begin
		if (RST) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && !ack_q) begin
			AVS_READDATA <= rd_d;
		end
	end

	// Timers: 0 on-delay, 1 off-delay, 2 pulse.
	swt_timer #(.MODE(`SWT_MODE_ON)) u_on_delay_timer (
		.clk(CLOCK), .rst(RST), .eval(eval_q[0]), .in_lvl(eval_in_q[0]),
		.preset(preset_q[0]), .now(ms_now_q), .et_q(et[0]), .q_q(timer_q0)
	);

	swt_timer #(.MODE(`SWT_MODE_OFF)) u_off_delay_timer (
		.clk(CLOCK), .rst(RST), .eval(eval_q[1]), .in_lvl(eval_in_q[1]),
		.preset(preset_q[1]), .now(ms_now_q), .et_q(et[1]), .q_q(timer_q1)
	);

	swt_timer #(.MODE(`SWT_MODE_PULSE)) u_pulse_timer (
		.clk(CLOCK), .rst(RST), .eval(eval_q[2]), .in_lvl(eval_in_q[2]),
		.preset(preset_q[2]), .now(ms_now_q), .et_q(et[2]), .q_q(timer_q2)
	);

endmodule // swt_top
`default_nettype wire

// ### test/swt_top_asserts.sv
// Concurrent checks on the ports of the scan watchdog and timer block.
// Assumes one clock, CLOCK, and a synchronous active-high RST.
`timescale 1ns/100ps
`default_nettype none

module swt_top_asserts #(
	parameter [31:0] TICK_CYCLES = 32'd10,
	parameter [31:0] DROP_CYCLES = 32'd50
) (
	// Clock and reset.
	input wire CLOCK,
	input wire RST,
	// Bus writes.
	input wire [6:0] AVS_ADDRESS,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire AVS_WAITREQUEST,
	// Pins and results.
	input wire PWR_OK,
	input wire MANUAL_RESET,
	input wire IRQ,
	input wire OUTPUT_EN,
	input wire CPU_HALT,
	input wire TASK_FIRE,
	input wire [2:0] TIMER_Q
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// Accepted writes to the timer evaluation and control words.
	wire eval_acc = AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == 7'h28);
	wire ctrl_acc = AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == 7'h00);
	logic [31:0] low_q;
	logic [31:0] gap_q;
	logic [3:0] cause_q;

	// Counts since supply loss, last task pulse and last cause able to restart outputs.
	// The gap and cause counts saturate so a long quiet spell never wraps into a false hit.
	always @(posedge CLOCK) begin
		if (RST) begin
			low_q <= 32'h0;
			gap_q <= 32'h0;
			cause_q <= 4'hf;
		end else begin
			low_q <= PWR_OK ? 32'h0 : low_q + 32'h1;
			gap_q <= TASK_FIRE ? 32'h0 : gap_q + {31'h0, ~gap_q[31]};
			cause_q <= (ctrl_acc || MANUAL_RESET || !PWR_OK) ? 4'h0 : cause_q + {3'h0, ~&cause_q};
		end
	end

	AST_HALT_INV: assert property (CPU_HALT == !OUTPUT_EN)
		else $error("halt flag is not the inverse of output enable");
	AST_Q_OFF: assert property (!OUTPUT_EN |-> TIMER_Q == 3'h0)
		else $error("timer outputs on while outputs are forced off");
	AST_RST_OFF: assert property (disable iff (1'b0) RST |=> !OUTPUT_EN && !IRQ && !TASK_FIRE && TIMER_Q == 3'h0)
		else $error("outputs not off after reset");
	AST_TASK_GAP: assert property (TASK_FIRE |-> gap_q >= TICK_CYCLES - 32'h1)
		else $error("task pulses closer than one tick");
	AST_DROP_HALT: assert property (low_q > DROP_CYCLES + 32'h8 |-> !OUTPUT_EN)
		else $error("outputs still on through a long dropout");
	AST_RISE_CAUSE: assert property ($rose(OUTPUT_EN) |-> cause_q <= 4'h8)
		else $error("outputs came back without a restart cause");
	AST_EVAL_ONLY: assert property (OUTPUT_EN && $past(OUTPUT_EN) && $past(OUTPUT_EN, 2) && TIMER_Q != $past(TIMER_Q)
		|-> $past(eval_acc) || $past(eval_acc, 2) || $past(eval_acc, 3))
		else $error("timer output changed without an evaluation");
	AST_ON_CLEAR: assert property (eval_acc && AVS_WRITEDATA[0] && !AVS_WRITEDATA[4] |-> ##2 !TIMER_Q[0])
		else $error("on-delay output stays on with input off");
	AST_OFF_SET: assert property (eval_acc && AVS_WRITEDATA[1] && AVS_WRITEDATA[5] |-> ##2 (TIMER_Q[1] || !OUTPUT_EN))
		else $error("off-delay output not on with input on");

	// Main scenarios reached.
	cover property (TASK_FIRE);
	cover property (IRQ);
	cover property ($fell(OUTPUT_EN) && PWR_OK);
	cover property (TIMER_Q[2]);
endmodule // swt_top_asserts

bind swt_top swt_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .DROP_CYCLES(DROP_CYCLES)) swt_top_asserts_i (
	.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PWR_OK(PWR_OK),
	.MANUAL_RESET(MANUAL_RESET), .IRQ(IRQ), .OUTPUT_EN(OUTPUT_EN), .CPU_HALT(CPU_HALT),
	.TASK_FIRE(TASK_FIRE), .TIMER_Q(TIMER_Q));
`default_nettype wire

// ### test/swt_top_test.sv
// Self-checking bench for the scan watchdog and timer block.
// Assumes short tick and dropout counts so every ms is ten clocks.
`timescale 1ns/100ps
`default_nettype none
`include "swt_defs.vh"

module swt_top_test;
	localparam [31:0] TICK = 32'd10;
	localparam [31:0] DROP = 32'd50;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [6:0] addr = 7'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic scan = 1'b0;
	logic pwr = 1'b1;
	logic man = 1'b0;
	wire [31:0] rdata;
	wire waitreq, irq, oen, halt, fire;
	wire [2:0] tq;
	int mismatches = 0;
	int checked = 0;
	int k;
	logic [31:0] seed = 32'hd2e0;
	logic [31:0] v, r1, p, n;

	swt_top #(.TICK_CYCLES(TICK), .DROP_CYCLES(DROP)) swt_top_i (
		.CLOCK(clock), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .SCAN_START(scan), .PWR_OK(pwr), .MANUAL_RESET(man),
		.IRQ(irq), .OUTPUT_EN(oen), .CPU_HALT(halt), .TASK_FIRE(fire), .TIMER_Q(tq));

	// Half period of 2 ns gives 250 MHz.
	always #2 clock = ~clock;

	// Repeatable xorshift source.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Verdict and end of run; called from the main sequence and on a hang.
	task automatic conclude();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One transfer held until waitrequest is sampled low at a rising edge, where read data
	// is taken; returns at the following falling edge so callers see the effect settled.
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (waitreq !== 1'b0 && i < 50);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clock);
		if (i >= 50) begin
			mismatches++;
			conclude();
		end
	endtask

	task automatic wrt(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [6:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	task automatic pulse_scan();
		@(posedge clock);
		scan <= 1'b1;
		@(posedge clock);
		scan <= 1'b0;
	endtask

	task automatic oen_is(input logic e);
		@(negedge clock);
		chk({31'h0, oen}, {31'h0, e});
		chk({31'h0, halt}, {31'h0, ~e});
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		// Reset values, an unmapped hole and the limit boundaries.
		rdc(`SWT_REG_WD_LIMIT, 32'h0000_00c8);
		rdc(`SWT_REG_SCAN_MIN, 32'hffff_ffff);
		rdc(7'h7c, 32'h0);
		oen_is(1'b0);
		wrt(`SWT_REG_WD_LIMIT, 32'h0);
		rdc(`SWT_REG_WD_LIMIT, 32'h1);
		wrt(`SWT_REG_WD_LIMIT, 32'hffff);
		rdc(`SWT_REG_WD_LIMIT, 32'hffff);
		wrt(`SWT_REG_CTRL, 32'h1);
		// Scans of whole ticks, the first one a single tick; the first start only arms.
		pulse_scan();
		v = 32'h0;
		p = 32'hffff_ffff;
		for (k = 0; k < 4; k++) begin
			n = (k == 0) ? 32'h1 : (rnd() & 32'h7) + 32'h1;
			v = (n > v) ? n : v;
			p = (n < p) ? n : p;
			repeat (n * TICK - 32'h2) @(posedge clock);
			pulse_scan();
		end
		rdc(`SWT_REG_SCAN_LATEST, n);
		rdc(`SWT_REG_SCAN_MAX, v);
		rdc(`SWT_REG_SCAN_MIN, p);
		// Timers: all inputs on, then off-delay and pulse inputs dropped, then wait out.
		p = (rnd() & 32'h3) + 32'h2;
		for (k = 0; k < 3; k++) begin
			wrt(`SWT_REG_PRESET0 + 7'(4 * k), p);
		end
		wrt(`SWT_REG_TMR_EVAL, 32'h77);
		@(negedge clock);
		chk({29'h0, tq}, 32'h6);
		wrt(`SWT_REG_TMR_EVAL, 32'h17);
		@(negedge clock);
		chk({29'h0, tq}, 32'h6);
		bus(1'b0, `SWT_REG_ELAPSED0, 32'h0, r1);
		repeat ((p + 32'h1) * TICK) @(posedge clock);
		rdc(`SWT_REG_ELAPSED0, r1);
		wrt(`SWT_REG_TMR_EVAL, 32'h17);
		@(negedge clock);
		chk({29'h0, tq}, 32'h1);
		for (k = 0; k < 3; k++) begin
			rdc(`SWT_REG_ELAPSED0 + 7'(4 * k), p);
		end
		wrt(`SWT_REG_TMR_EVAL, 32'h07);
		@(negedge clock);
		chk({29'h0, tq}, 32'h0);
		rdc(`SWT_REG_ELAPSED0, 32'h0);
		// Periodic task: a window of three whole intervals holds three pulses.
		n = (rnd() & 32'h3) + 32'h1;
		wrt(`SWT_REG_TASK_IVL, n);
		repeat (32'h2 * n * TICK) @(posedge clock);
		k = 0;
		repeat (32'h3 * n * TICK) begin
			@(negedge clock);
			k = k + ((fire === 1'b1) ? 1 : 0);
		end
		chk(32'(k), 32'h3);
		// Interrupt raised, masked and cleared once the task is stopped.
		wrt(`SWT_REG_IRQ_MASK, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wrt(`SWT_REG_IRQ_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wrt(`SWT_REG_IRQ_MASK, 32'h4);
		wrt(`SWT_REG_TASK_IVL, 32'h0);
		wrt(`SWT_REG_STATUS, 32'h4);
		chk({31'h0, irq}, 32'h0);
		// Watchdog kept quiet by scan starts and restart requests, then overrunning.
		wrt(`SWT_REG_CMD, 32'h1);
		wrt(`SWT_REG_WD_LIMIT, 32'h3);
		for (k = 0; k < 6; k++) begin
			repeat (32'h2 * TICK) @(posedge clock);
			if (k % 2 == 1) begin
				pulse_scan();
			end else begin
				wrt(`SWT_REG_CMD, 32'h1);
			end
			oen_is(1'b1);
		end
		repeat (32'h5 * TICK) @(posedge clock);
		oen_is(1'b0);
		rdc(`SWT_REG_STATE, 32'h3);
		@(posedge clock);
		man <= 1'b1;
		repeat (4) @(posedge clock);
		man <= 1'b0;
		oen_is(1'b1);
		repeat (32'h5 * TICK) @(posedge clock);
		oen_is(1'b0);
		wrt(`SWT_REG_CTRL, 32'h0);
		rdc(`SWT_REG_STATE, 32'h0);
		wrt(`SWT_REG_WD_LIMIT, 32'hffff);
		wrt(`SWT_REG_CTRL, 32'h1);
		// Short supply loss rides through; a long one halts and recovers by itself.
		@(posedge clock);
		pwr <= 1'b0;
		k = 0;
		repeat (DROP / 32'h2) begin
			@(negedge clock);
			k = k + ((oen !== 1'b1) ? 1 : 0);
		end
		chk(32'(k), 32'h0);
		@(posedge clock);
		pwr <= 1'b1;
		repeat (10) @(posedge clock);
		pwr <= 1'b0;
		repeat (DROP + 32'ha) @(posedge clock);
		oen_is(1'b0);
		rdc(`SWT_REG_STATE, 32'h5);
		@(posedge clock);
		pwr <= 1'b1;
		repeat (6) @(posedge clock);
		oen_is(1'b1);
		conclude();
	end
endmodule // swt_top_test
`default_nettype wire
